//--- include/eepc_consts.svh
`ifndef EEPC_CONSTS_SVH
`define EEPC_CONSTS_SVH
// ----------------------------------------
// Register map and field layout
// ----------------------------------------
`define EEPC_OFF_EEPROM_PROGRAM_CONTROL_CTRL 8'h1c
`define EEPC_OFF_ARRAY_BASE 8'h80
`define EEPC_ARRAY_MASK 8'h80
`define EEPC_RESET_VAL 8'h00
`define EEPC_CTRL_MASK 8'h5f
`define EEPC_BIT_PUMP 6
`define EEPC_BIT_ER_HI 4
`define EEPC_BIT_ER_LO 3
`define EEPC_BIT_LATCH 2
`define EEPC_BIT_RC 1
`define EEPC_BIT_POWER 0
`define EEPC_ERASED_BYTE 8'hff
`define EEPC_ADDR_W 7
`define EEPC_BLOCK_SHIFT 5
`define EEPC_NBYTES 128
`define EEPC_TICK_PS 8000
`endif

//--- include/eepc_pkg.sv
package eepc_pkg;
    typedef enum logic [1:0] {
        EEPC_MODE_PROGRAM,
        EEPC_MODE_BYTE_ERASE,
        EEPC_MODE_BLOCK_ERASE,
        EEPC_MODE_BULK_ERASE
    } eepc_mode_t;
    typedef enum logic [1:0] {
        EEPC_ST_IDLE,
        EEPC_ST_ARMED,
        EEPC_ST_POWERED
    } eepc_state_t;
endpackage

//--- logic/eepc_cell.sv
`timescale 1ns/1ps
`default_nettype none
`include "eepc_consts.svh"
module eepc_cell (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Operation strobes
    input wire logic tick,
    input wire logic sel,
    input wire logic do_erase,
    input wire logic do_eeprom_program_control,
    input wire logic [7:0] eeprom_program_control_data,
    // Cell content
    output logic [7:0] q
);
    // Erase drives ones, programming can only clear bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= `EEPC_ERASED_BYTE;
        end else if (tick && sel) begin
            if (do_erase) begin
                q <= `EEPC_ERASED_BYTE;
            end else if (do_eeprom_program_control) begin
                q <= q & eeprom_program_control_data;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/eepc_ctrl.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "eepc_consts.svh"
// Summary of operation
// - Bit 6 switches the charge pump on; read/write; reset clears it.
// - Array power only flows when pump and power enable are both set.
// - Bits 4:3 pick program, byte, block or bulk erase; reset 00.
// - Byte erase hits one byte; block erase hits the aligned 32-byte block.
// - Bulk erase wipes all 128 bytes on a write anywhere.
// - With latch bit set, the first array write captures address and data.
// - Array reads blocked while latched and a write was captured.
// - Bit 1 clocks the array section from the RC oscillator.
// - Bit 0 applies programming power; clearing removes it; reset clears.
// - Power bit readable always, writable only while latch is set.
// - Any reset aborts an operation at once; every byte reloads the erased value 8'hff.
// - Erased cells read one; programming only clears bits.
// - Stop mode turns the RC oscillator off automatically.
module eepc_ctrl (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Clocking and power state
    input wire logic rc_osc_tick,
    input wire logic stop_mode,
    output logic rc_osc_run,
    output logic pump_running,
    output logic array_power,
    output logic read_blocked
);
    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic addr_take;
    assign addr_take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0;

    // Register the address phase for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= addr_take;
            dp_write <= hwrite;
            dp_addr <= haddr[9:2];
        end
    end

    // Word address decode; array takes one word per byte
    logic sel_ctrl;
    logic sel_array;
    logic [`EEPC_ADDR_W-1:0] arr_idx;
    assign sel_ctrl = dp_valid && (dp_addr == (`EEPC_OFF_EEPROM_PROGRAM_CONTROL_CTRL >> 2));
    assign sel_array = dp_valid && ((dp_addr & `EEPC_ARRAY_MASK) == `EEPC_OFF_ARRAY_BASE);
    assign arr_idx = dp_addr[`EEPC_ADDR_W-1:0];

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] wdat;
    assign wdat = hwdata[7:0];

    // Write merge; unused bits forced to zero
    always_comb begin
        next_ctrl = ctrl;
        if (sel_ctrl && dp_write) begin
            next_ctrl = wdat & `EEPC_CTRL_MASK;
            if (!ctrl[`EEPC_BIT_LATCH]) begin
                next_ctrl[`EEPC_BIT_POWER] = ctrl[`EEPC_BIT_POWER];
            end
            // Power cannot outlive the latch that armed it
            if (!next_ctrl[`EEPC_BIT_LATCH]) begin
                next_ctrl[`EEPC_BIT_POWER] = 1'b0;
            end
        end
    end

    // Async reset clears every bit, aborting any operation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `EEPC_RESET_VAL;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    logic latch_on;
    logic rc_sel;
    eepc_pkg::eepc_mode_t mode;
    assign latch_on = ctrl[`EEPC_BIT_LATCH];
    assign rc_sel = ctrl[`EEPC_BIT_RC];
    assign mode = eepc_pkg::eepc_mode_t'(ctrl[`EEPC_BIT_ER_HI:`EEPC_BIT_ER_LO]);

    // Pump drives the rail; array sees it only with power enable
    assign pump_running = ctrl[`EEPC_BIT_PUMP];
    assign array_power = ctrl[`EEPC_BIT_PUMP] && ctrl[`EEPC_BIT_POWER];

    // Stop mode kills the oscillator regardless of the select bit
    assign rc_osc_run = rc_sel && !stop_mode;

    // ----------------------------------------
    // Address and data latch
    // ----------------------------------------
    eepc_pkg::eepc_state_t state;
    logic [`EEPC_ADDR_W-1:0] lat_addr;
    logic [7:0] lat_data;

    // Capture first array write while latched; one target per sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= eepc_pkg::EEPC_ST_IDLE;
            lat_addr <= '0;
            lat_data <= 8'h00;
        end else begin
            case (state)
                eepc_pkg::EEPC_ST_IDLE: begin
                    if (latch_on && sel_array && dp_write) begin
                        state <= eepc_pkg::EEPC_ST_ARMED;
                        lat_addr <= arr_idx;
                        lat_data <= wdat;
                    end
                end
                eepc_pkg::EEPC_ST_ARMED: begin
                    if (!next_ctrl[`EEPC_BIT_LATCH]) begin
                        state <= eepc_pkg::EEPC_ST_IDLE;
                    end else if (array_power) begin
                        state <= eepc_pkg::EEPC_ST_POWERED;
                    end
                end
                eepc_pkg::EEPC_ST_POWERED: begin
                    if (!next_ctrl[`EEPC_BIT_LATCH]) begin
                        state <= eepc_pkg::EEPC_ST_IDLE;
                    end else if (!array_power) begin
                        state <= eepc_pkg::EEPC_ST_ARMED;
                    end
                end
                default: begin
                    state <= eepc_pkg::EEPC_ST_IDLE;
                end
            endcase
        end
    end

    assign read_blocked = latch_on && (state != eepc_pkg::EEPC_ST_IDLE);

    // ----------------------------------------
    // Array clocking and cells
    // ----------------------------------------
    // Section clock: every bus clock, or the RC tick when selected
    logic tick;
    assign tick = rc_sel ? (rc_osc_tick && !stop_mode) : 1'b1;

    logic op_erase;
    logic op_eeprom_program_control;
    assign op_erase = (state == eepc_pkg::EEPC_ST_POWERED) && array_power && (mode != eepc_pkg::EEPC_MODE_PROGRAM);
    assign op_eeprom_program_control = (state == eepc_pkg::EEPC_ST_POWERED) && array_power && (mode == eepc_pkg::EEPC_MODE_PROGRAM);

    logic [7:0] cell_q [`EEPC_NBYTES];
    genvar gi;
    generate
        for (gi = 0; gi < `EEPC_NBYTES; gi++) begin : g_cell
            logic hit;
            always_comb begin
                case (mode)
                    eepc_pkg::EEPC_MODE_BULK_ERASE: hit = 1'b1;
                    eepc_pkg::EEPC_MODE_BLOCK_ERASE: begin
                        hit = ((`EEPC_ADDR_W)'(gi) >> `EEPC_BLOCK_SHIFT) == (lat_addr >> `EEPC_BLOCK_SHIFT);
                    end
                    default: hit = (`EEPC_ADDR_W)'(gi) == lat_addr;
                endcase
            end
            eepc_cell u_cell (
                .hclk(hclk),
                .hresetn(hresetn),
                .tick(tick),
                .sel(hit),
                .do_erase(op_erase),
                .do_eeprom_program_control(op_eeprom_program_control),
                .eeprom_program_control_data(lat_data),
                .q(cell_q[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Blocked array reads return zero rather than stale latch data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            if (haddr[9:2] == (`EEPC_OFF_EEPROM_PROGRAM_CONTROL_CTRL >> 2)) begin
                hrdata <= {24'h00_0000, next_ctrl};
            end else if ((haddr[9:2] & `EEPC_ARRAY_MASK) == `EEPC_OFF_ARRAY_BASE) begin
                hrdata <= read_blocked ? 32'h0000_0000 : {24'h00_0000, cell_q[haddr[8:2]]};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/eepc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module eepc_ctrl_chk (
    // Bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Section status
    input wire logic stop_mode,
    input wire logic rc_osc_run,
    input wire logic pump_running,
    input wire logic array_power,
    input wire logic read_blocked
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Control write up to its data edge; reads in address phase
    sequence s_wr;
        hsel && hready && htrans[1] && hwrite && haddr == 32'h1c ##1 hready;
    endsequence
    sequence s_crd;
        hsel && hready && htrans[1] && !hwrite && haddr == 32'h1c;
    endsequence
    sequence s_ard;
        hsel && hready && htrans[1] && !hwrite && haddr[31:9] == 23'h1;
    endsequence
    property p_pon; s_wr ##0 hwdata[6] |=> pump_running; endproperty
    a_pon: assert property (p_pon) else $error("pump not on");
    property p_poff; s_wr ##0 !hwdata[6] |=> !pump_running && !array_power; endproperty
    a_poff: assert property (p_poff) else $error("pump not off");
    property p_pwr; array_power |-> pump_running; endproperty
    a_pwr: assert property (p_pwr) else $error("power without pump");
    property p_pclr; s_wr ##0 !hwdata[0] |=> !array_power; endproperty
    a_pclr: assert property (p_pclr) else $error("power not removed");
    property p_rc; s_wr ##0 hwdata[1] |=> rc_osc_run || stop_mode; endproperty
    a_rc: assert property (p_rc) else $error("rc clock not run");
    property p_stop; stop_mode |-> !rc_osc_run; endproperty
    a_stop: assert property (p_stop) else $error("rc runs in stop");
    property p_blk; s_ard ##0 read_blocked |=> hrdata == 32'h0; endproperty
    a_blk: assert property (p_blk) else $error("blocked read leaks");
    property p_crd; s_crd |=> !hrdata[7] && !hrdata[5] && hrdata[6] == pump_running; endproperty
    a_crd: assert property (p_crd) else $error("control readback");
    property p_rst; $rose(hresetn) |-> !array_power && !pump_running && !read_blocked; endproperty
    a_rst: assert property (p_rst) else $error("state after reset");
endmodule
bind eepc_ctrl eepc_ctrl_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .stop_mode, .rc_osc_run, .pump_running, .array_power, .read_blocked);
`default_nettype wire

//--- sim/eepc_rc_osc.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// RC oscillator model
// ----------------------------------------
module eepc_rc_osc #(
    parameter int DIV = 3
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Oscillator
    input wire logic run,
    output logic tick
);
    logic [3:0] cnt;
    // Slow pulse train; silent when disabled so stop mode really stalls the section
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn || !run) begin
            cnt <= 4'h0;
            tick <= 1'b0;
        end else begin
            cnt <= (cnt == 4'(DIV - 1)) ? 4'h0 : cnt + 4'h1;
            tick <= (cnt == 4'(DIV - 1));
        end
    end
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Testbench top
// ----------------------------------------
module tb;
    logic hclk, hresetn, hsel, hwrite, stop_mode, rd_dp, hreadyout, hresp, tick;
    logic rc_osc_run, pump_running, array_power, read_blocked;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [31:0] q[$];
    logic [7:0] e[128];
    int fails, total_checks;
    localparam logic [31:0] CTRL = 32'h1c;
    eepc_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rc_osc_tick(tick), .stop_mode, .rc_osc_run,
        .pump_running, .array_power, .read_blocked);
    eepc_rc_osc i_osc (.hclk, .hresetn, .run(rc_osc_run), .tick);
    // Clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task end_sim;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, g, x);
        end
    endtask
    // Flags looked at once the write edge has landed
    task flg(input logic [3:0] x);
        // Bus handshake outputs ride along: always ready, always OKAY
        #1 cmp({26'h0, hreadyout, hresp, pump_running, array_power, read_blocked, rc_osc_run}, {26'h0, 2'b10, x});
        @(posedge hclk);
    endtask
    // Bounded wait for hready
    task wt;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                end_sim;
            end
            @(posedge hclk);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite} <= 4'hd;
        haddr <= a;
        wt;
        {hsel, htrans} <= 3'h0;
        hwdata <= d;
        wt;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] x);
        {hsel, htrans, hwrite} <= 4'hc;
        haddr <= a;
        q.push_back(x);
        wt;
        {hsel, htrans} <= 3'h0;
        wt;
    endtask
    // Read data checked at the end of each data phase
    always @(posedge hclk) begin
        if (rd_dp) cmp(hrdata, q.size() > 0 ? q.pop_front() : 32'hx);
        rd_dp <= hsel && htrans[1] && !hwrite;
    end
    // One full program or erase pass, with the expected array kept alongside
    task op(input logic [1:0] m, input int i, input logic [7:0] d, input logic rc);
        logic [7:0] v;
        v = {3'b010, m, 1'b1, rc, 1'b0};
        wr(CTRL, {24'h0, v});
        // Slow section clock needs time to settle before the array is touched
        if (rc) repeat (4) @(posedge hclk);
        wr(32'h200 + 4 * i, {24'h0, d});
        flg({3'b101, rc});
        rd(32'h200 + 4 * i, 32'h0);
        wr(CTRL, {24'h0, v | 8'h01});
        flg({3'b111, rc});
        repeat (8) @(posedge hclk);
        wr(CTRL, {24'h0, v});
        repeat (2) @(posedge hclk);
        wr(CTRL, 32'h0);
        for (int j = 0; j < 128; j++)
            if (m == 3 || (m == 2 && j / 32 == i / 32) || (m == 1 && j == i)) e[j] = 8'hff;
        if (m == 0) e[i] = e[i] & d;
        rd(32'h200 + 4 * i, {24'h0, e[i]});
    endtask
    // Main sequence
    initial begin
        {hsel, htrans, hwrite, haddr, hwdata, stop_mode, hresetn} = '0;
        fails = 0;
        total_checks = 0;
        for (int j = 0; j < 128; j++) e[j] = 8'hff;
        void'($urandom(24));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(CTRL, 32'h0);
        rd(32'h3fc, 32'hff);
        wr(CTRL, 32'hff);
        rd(CTRL, 32'h5e);
        flg(4'b1001);
        stop_mode <= 1'b1;
        flg(4'b1000);
        stop_mode <= 1'b0;
        wr(CTRL, 32'h0);
        wr(32'h40, 32'h5a);
        rd(32'h40, 32'h0);
        $display("register test done");
        for (int k = 0; k < 3; k++) op(2'h0, 5 + 35 * k, 8'($urandom), k[0]);
        op(2'h0, 5, 8'($urandom), 1'b0);
        op(2'h1, 5, 8'h0, 1'b0);
        rd(32'h2a0, {24'h0, e[40]});
        op(2'h2, 45, 8'h0, 1'b1);
        rd(32'h32c, {24'h0, e[75]});
        op(2'h3, 127, 8'h0, 1'b0);
        rd(32'h32c, 32'hff);
        $display("array test done");
        wr(CTRL, 32'h44);
        wr(32'h228, 32'h0);
        wr(CTRL, 32'h45);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(CTRL, 32'h0);
        flg(4'b0000);
        $display("reset abort test done");
        end_sim;
    end
endmodule
`default_nettype wire
